/* rtl/osc_cfg.svh */
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH
// bus widths
`define ADDR_W 14
`define DATA_W 14
// register addresses
`define ADDR_CFG1 14'h2007
`define ADDR_CFG2 14'h2008
`define ADDR_CTRL 14'h0010
`define ADDR_TRIM 14'h0011
// configuration word fields
`define CFG_ERASED 14'h3fff
`define CFG_PLL_BIT 12
`define CFG_FOSC_HI 1
`define CFG_FOSC_LO 0
`define FOSC_EXT_CLOCK_OUTPUT_PIN 2'h3
`define FOSC_EXT_IO 2'h2
`define FOSC_INT_CLOCK_OUTPUT_PIN 2'h1
`define FOSC_INT_IO 2'h0
// control and tuning fields
`define CTRL_IFS_HI 5
`define CTRL_IFS_LO 4
`define CTRL_LOCK_BIT 3
`define CTRL_STAB_BIT 2
`define IFS_RESET 2'h2
`define TRIM_W 6
`define TRIM_HI 5
`define TRIM_RESET 6'h00
// postscaler masks for divide by 1, 2, 4, 8
`define PS_MASK_DIV1 3'h0
`define PS_MASK_DIV2 3'h1
`define PS_MASK_DIV4 3'h3
`define PS_MASK_DIV8 3'h7
// rates: mclk 50 MHz, high base 16 MHz, mid base 500 kHz
`define MCLK_HZ 64'h0000_0000_02fa_f080
`define HF_HZ 64'h0000_0000_00f4_2400
`define MF_HZ 64'h0000_0000_0007_a120
`define MCLK_PERIOD_NS 32'h0000_0014
`define ACC_W 24
`define TRIM_SHIFT 8
// times in ns: lock 4000, stable 8000, trim step 1000
`define LOCK_TIME_NS 32'h0000_0fa0
`define STABLE_TIME_NS 32'h0000_1f40
`define STEP_TIME_NS 32'h0000_03e8
`define CYC_UP(ns) (((ns) + `MCLK_PERIOD_NS - 32'h0000_0001) / `MCLK_PERIOD_NS)
`define SETTLE_W 10
`define LOCK_CYC 10'(`CYC_UP(`LOCK_TIME_NS))
`define STABLE_CYC 10'(`CYC_UP(`STABLE_TIME_NS))
`define STEP_CYC 6'(`CYC_UP(`STEP_TIME_NS))
`endif

/* rtl/osc_pkg.sv */
package osc_pkg;
`include "osc_cfg.svh"
  // clock source modes
  typedef enum {EXT_CLOCK_OUTPUT_PIN, EXT_IO, INT_CLOCK_OUTPUT_PIN, INT_IO} src_mode_t;
  // three-flop pin synchroniser
  typedef struct packed {
    logic [2:0] ff;
    logic       level;
    logic       rise;
  } sync_state_t;
  // tunable phase oscillator
  typedef struct packed {
    logic [`ACC_W-1:0]  acc;
    logic [`TRIM_W-1:0] trim_eff;
    logic [5:0]         step_cnt;
    logic               tick;
  } osc_state_t;
  // clock control block
  typedef struct packed {
    logic [`DATA_W-1:0]   cfg1;
    logic [`DATA_W-1:0]   cfg2;
    logic [1:0]           ifs;
    logic [`TRIM_W-1:0]   trim;
    logic [`SETTLE_W-1:0] settle;
    logic                 locked;
    logic                 stable;
    logic [2:0]           ps_cnt;
    logic [1:0]           clk_cnt;
    logic                 fosc_tick;
    logic                 clock_input_pin_free;
    logic                 clock_output_pin_free;
    logic                 clock_output_pin_oe;
    logic [`DATA_W-1:0]   rdata;
  } ctl_state_t;
endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
`include "osc_cfg.svh"
module pin_sync import osc_pkg::*; (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // pin and result
  input  wire logic pin,
  output logic      level,
  output logic      rise
);
  sync_state_t st_reg;
  sync_state_t st_next;

  // level moves only when the second and third flops agree
  always_comb begin
    st_next = st_reg;
    st_next.ff = {st_reg.ff[1:0], pin};
    st_next.rise = 1'b0;
    if (st_reg.ff[1] == st_reg.ff[2]) begin
      st_next.level = st_reg.ff[2];
      st_next.rise = st_reg.ff[2] & ~st_reg.level;
    end
    if (rst) begin
      st_next = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end

  assign level = st_reg.level;
  assign rise  = st_reg.rise;
endmodule // pin_sync

/* rtl/trim_osc.sv */
`timescale 1ns/1ps
`include "osc_cfg.svh"
module trim_osc import osc_pkg::*; (
  // clock and resets
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              por_bor,
  // settings
  input  wire logic              pll_en,
  input  wire logic [`TRIM_W-1:0] trim_target,
  // oscillator output
  output logic                   base_tick,
  output logic                   trim_settled
);
  localparam logic [`ACC_W-1:0] HF_INC = `ACC_W'((`HF_HZ << `ACC_W) / `MCLK_HZ);
  localparam logic [`ACC_W-1:0] MF_INC = `ACC_W'((`MF_HZ << `ACC_W) / `MCLK_HZ);

  osc_state_t         st_reg;
  osc_state_t         st_next;
  logic signed [31:0] base_s;
  logic signed [31:0] trim_s;
  logic signed [31:0] prod;
  logic [`ACC_W:0]    sum;

  // signed offset scales the base step monotonically
  always_comb begin
    base_s  = $signed({8'h00, (pll_en ? HF_INC : MF_INC)});
    trim_s  = 32'(signed'(st_reg.trim_eff));
    prod    = base_s * trim_s;
    sum     = {1'b0, st_reg.acc} + {1'b0, `ACC_W'(base_s + (prod >>> `TRIM_SHIFT))};
    st_next = st_reg;
    st_next.acc  = sum[`ACC_W-1:0];
    st_next.tick = sum[`ACC_W];
    // glide one step at a time; trim_settled flags completion
    if (st_reg.trim_eff != trim_target) begin
      st_next.step_cnt = st_reg.step_cnt + 6'h01;
      if (st_reg.step_cnt == `STEP_CYC - 6'h01) begin
        st_next.step_cnt = 6'h00;
        if ($signed(trim_target) > $signed(st_reg.trim_eff)) begin
          st_next.trim_eff = st_reg.trim_eff + 6'h01;
        end else begin
          st_next.trim_eff = st_reg.trim_eff - 6'h01;
        end
      end
    end
    if (rst || por_bor) begin
      st_next.acc = '0;
      st_next.tick = 1'b0;
      st_next.step_cnt = 6'h00;
    end
    if (por_bor) begin
      st_next.trim_eff = `TRIM_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end

  assign base_tick    = st_reg.tick;
  assign trim_settled = (st_reg.trim_eff == trim_target);

  a_base_fast_rate: assert property (@(posedge mclk) disable iff (rst || por_bor)
    pll_en && base_tick |-> ##[1:4] (base_tick || !pll_en))
    else $error("high base tick too slow");
  a_base_slow_rate: assert property (@(posedge mclk) disable iff (rst || por_bor)
    !pll_en && base_tick |=> (!base_tick || pll_en) [*8])
    else $error("low base tick too fast");
  a_trim_glide_step: assert property (@(posedge mclk) disable iff (rst || por_bor)
    $changed(st_reg.trim_eff) |-> (6'(st_reg.trim_eff - $past(st_reg.trim_eff)) inside {6'h01, 6'h3f}))
    else $error("trim jumped by more than one step");
endmodule // trim_osc

/* rtl/osc_clock_ctrl.sv */
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "osc_cfg.svh"
// -----------------------------------------------------------------
// -----------------------------------------------------------------
module osc_clock_ctrl import osc_pkg::*; (
  // clock and resets
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               por_bor,
  // register port
  input  wire logic [`ADDR_W-1:0] addr,
  input  wire logic [`DATA_W-1:0] wdata,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  input  wire logic               prog_mode,
  output logic [`DATA_W-1:0]      rdata,
  // clock pins
  input  wire logic               clock_input_pin,
  output logic                    clock_output_pin,
  output logic                    clock_output_pin_oe,
  output logic                    clock_input_pin_gpio_free,
  output logic                    clock_output_pin_gpio_free,
  // system clock and status
  output logic                    fosc_tick,
  output logic                    osc_locked_flag,
  output logic                    osc_stable_flag
);

  // -----------------------------------------------------------------
  // decoding helpers
  // -----------------------------------------------------------------

  // source select field to mode
  function automatic src_mode_t decode_src(input logic [1:0] fosc);
    src_mode_t m;
    m = INT_IO;
    unique case (fosc)
      `FOSC_EXT_CLOCK_OUTPUT_PIN: m = EXT_CLOCK_OUTPUT_PIN;
      `FOSC_EXT_IO:     m = EXT_IO;
      `FOSC_INT_CLOCK_OUTPUT_PIN: m = INT_CLOCK_OUTPUT_PIN;
      `FOSC_INT_IO:     m = INT_IO;
    endcase
    return m;
  endfunction

  // postscaler mask: all ones in the masked bits marks an output tick
  function automatic logic [2:0] postscale_mask(input logic [1:0] ifs);
    logic [2:0] m;
    m = `PS_MASK_DIV1;
    unique case (ifs)
      2'h3: m = `PS_MASK_DIV1;
      2'h2: m = `PS_MASK_DIV2;
      2'h1: m = `PS_MASK_DIV4;
      2'h0: m = `PS_MASK_DIV8;
    endcase
    return m;
  endfunction

  // -----------------------------------------------------------------
  // state and sub-blocks
  // -----------------------------------------------------------------

  ctl_state_t st_reg;
  ctl_state_t st_next;
  src_mode_t  src;
  logic       is_ext;
  logic       has_clock_output_pin;
  logic       pll_base_enable;
  logic       base_tick;
  logic       trim_settled;
  logic       ext_level;
  logic       ext_rise;
  logic       int_tick;
  logic       sys_tick;
  logic [2:0] ps_mask;
  logic [`DATA_W-1:0] rd_value;

  // external clock arrives asynchronously, so it is synchronised first
  pin_sync u_ext_sync (
    .mclk  (mclk),
    .rst   (rst),
    .pin   (clock_input_pin),
    .level (ext_level),
    .rise  (ext_rise)
  );

  // both base rates come from one running oscillator
  trim_osc u_osc (
    .mclk         (mclk),
    .rst          (rst),
    .por_bor      (por_bor),
    .pll_en       (pll_base_enable),
    .trim_target  (st_reg.trim),
    .base_tick    (base_tick),
    .trim_settled (trim_settled)
  );

  // -----------------------------------------------------------------
  // source and pin decode
  // -----------------------------------------------------------------

  // configuration words act as fixed settings outside programming
  always_comb begin
    src             = decode_src(st_reg.cfg1[`CFG_FOSC_HI:`CFG_FOSC_LO]);
    is_ext          = (src == EXT_CLOCK_OUTPUT_PIN) || (src == EXT_IO);
    has_clock_output_pin      = (src == EXT_CLOCK_OUTPUT_PIN) || (src == INT_CLOCK_OUTPUT_PIN);
    pll_base_enable = st_reg.cfg1[`CFG_PLL_BIT];
  end

  // -----------------------------------------------------------------
  // system clock selection
  // -----------------------------------------------------------------

  // postscaler runs free, so a new select needs no restart
  always_comb begin
    ps_mask  = postscale_mask(st_reg.ifs);
    int_tick = base_tick && ((st_reg.ps_cnt & ps_mask) == ps_mask);
    // external mode uses the synchronised pin edge directly
    sys_tick = is_ext ? ext_rise : int_tick;
  end

  // -----------------------------------------------------------------
  // register read decode
  // -----------------------------------------------------------------

  // unimplemented bits are built as zeros, never stored
  always_comb begin
    rd_value = '0;
    if (addr == `ADDR_CTRL) begin
      rd_value[`CTRL_IFS_HI:`CTRL_IFS_LO] = st_reg.ifs;
      rd_value[`CTRL_LOCK_BIT]            = st_reg.locked;
      rd_value[`CTRL_STAB_BIT]            = st_reg.stable;
    end else if (addr == `ADDR_TRIM) begin
      rd_value[`TRIM_HI:0] = st_reg.trim;
    end else if (prog_mode && addr == `ADDR_CFG1) begin
      rd_value = st_reg.cfg1;
    end else if (prog_mode && addr == `ADDR_CFG2) begin
      rd_value = st_reg.cfg2;
    end
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------

  always_comb begin
    st_next = st_reg;
    // read data stand for the single cycle after the strobe
    st_next.rdata = rd_en ? rd_value : '0;

    // register writes; only implemented fields are kept
    if (wr_en && addr == `ADDR_CTRL) begin
      st_next.ifs = wdata[`CTRL_IFS_HI:`CTRL_IFS_LO];
    end
    if (wr_en && addr == `ADDR_TRIM) begin
      st_next.trim = wdata[`TRIM_HI:0];
    end
    if (wr_en && prog_mode && addr == `ADDR_CFG1) begin
      st_next.cfg1 = wdata;
    end
    if (wr_en && prog_mode && addr == `ADDR_CFG2) begin
      st_next.cfg2 = wdata;
    end

    // settle timer saturates at the stable point
    if (st_reg.settle != `STABLE_CYC) begin
      st_next.settle = st_reg.settle + `SETTLE_W'(1);
    end
    st_next.locked = (st_next.settle >= `LOCK_CYC);
    // a pending tuning glide costs the finer accuracy
    st_next.stable = (st_next.settle == `STABLE_CYC) && trim_settled;

    // postscaler and clock output divider
    if (base_tick) begin
      st_next.ps_cnt = st_reg.ps_cnt + 3'h1;
    end
    st_next.fosc_tick = sys_tick;
    if (sys_tick) begin
      st_next.clk_cnt = st_reg.clk_cnt + 2'h1;
    end

    // pin ownership follows the fixed source mode
    st_next.clock_input_pin_free  = !is_ext;
    st_next.clock_output_pin_free = !has_clock_output_pin;
    st_next.clock_output_pin_oe   = has_clock_output_pin;

    // any reset
    if (rst || por_bor) begin
      st_next.ifs         = `IFS_RESET;
      st_next.settle      = '0;
      st_next.locked      = 1'b0;
      st_next.stable      = 1'b0;
      st_next.ps_cnt      = 3'h0;
      st_next.clk_cnt     = 2'h0;
      st_next.fosc_tick   = 1'b0;
      st_next.clock_input_pin_free  = 1'b0;
      st_next.clock_output_pin_free = 1'b0;
      st_next.clock_output_pin_oe   = 1'b0;
      st_next.rdata       = '0;
    end
    // tuning and configuration survive an ordinary reset
    if (por_bor) begin
      st_next.trim = `TRIM_RESET;
      st_next.cfg1 = `CFG_ERASED;
      st_next.cfg2 = `CFG_ERASED;
    end
  end

  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------

  assign rdata            = st_reg.rdata;
  assign clock_output_pin = st_reg.clk_cnt[1];
  assign clock_output_pin_oe        = st_reg.clock_output_pin_oe;
  assign clock_input_pin_gpio_free  = st_reg.clock_input_pin_free;
  assign clock_output_pin_gpio_free = st_reg.clock_output_pin_free;
  assign fosc_tick        = st_reg.fosc_tick;
  assign osc_locked_flag  = st_reg.locked;
  assign osc_stable_flag  = st_reg.stable;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || por_bor);

  a_src_clock_output_pin_oe: assert property (
    ##1 clock_output_pin_oe == ($past(st_reg.cfg1[`CFG_FOSC_LO]) && !$past(rst)))
    else $error("clock output enable does not follow source select");

  a_clock_output_pin_div_four: assert property (
    $changed(clock_output_pin) |-> fosc_tick && $past(st_reg.clk_cnt[0]))
    else $error("clock output moved off a quarter boundary");

  a_io_mode_release: assert property (
    src == INT_IO && !prog_mode |=> clock_input_pin_gpio_free && clock_output_pin_gpio_free && !clock_output_pin_oe)
    else $error("io mode still holds a clock pin");

  a_clock_input_pin_left_free: assert property (
    src == INT_CLOCK_OUTPUT_PIN && !prog_mode |=> clock_input_pin_gpio_free && clock_output_pin_oe)
    else $error("clock out mode did not free the input pin");

  a_postscale_pick: assert property (
    fosc_tick && !$past(is_ext) |->
      ($past(st_reg.ps_cnt) & postscale_mask($past(st_reg.ifs))) == postscale_mask($past(st_reg.ifs)))
    else $error("system tick off the selected postscale");

  a_ifs_reset_val: assert property (disable iff (1'b0)
    rst |=> st_reg.ifs == `IFS_RESET)
    else $error("frequency select not reset to its default");

  a_lock_timing: assert property (
    $rose(osc_locked_flag) |-> st_reg.settle == `LOCK_CYC)
    else $error("locked flag rose at the wrong time");

  a_stable_cause: assert property (
    osc_stable_flag |-> osc_locked_flag && $past(trim_settled))
    else $error("stable flag set while unlocked or gliding");

  a_unimpl_zero: assert property (
    rd_en && (addr == `ADDR_CTRL || addr == `ADDR_TRIM) |=> rdata[13:6] == 8'h00 && !(rdata[1:0] != 2'h0 &&
      $past(addr) == `ADDR_CTRL))
    else $error("unimplemented bits read non-zero");

  a_trim_keep: assert property (disable iff (1'b0)
    rst && !por_bor |=> $stable(st_reg.trim))
    else $error("tuning lost over an ordinary reset");

  a_cfg_hidden: assert property (
    rd_en && !prog_mode && (addr == `ADDR_CFG1 || addr == `ADDR_CFG2) |=> rdata == '0)
    else $error("configuration word visible outside programming");

endmodule // osc_clock_ctrl

/* tb/ext_clk_src.sv */
`timescale 1ns/1ps
// -----------------------------
// external logic-level clock
// -----------------------------
module ext_clk_src #(
  parameter int HALF_NS = 103
) (
  // control
  input  wire logic run,
  // clock pin
  output logic      clk_pin
);
  // held low when idle so no stray edge reaches the pin
  initial clk_pin = 1'b0;
  always begin
    #(HALF_NS);
    clk_pin = run ? ~clk_pin : 1'b0;
  end
endmodule // ext_clk_src

/* tb/osc_clock_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "osc_cfg.svh"
module osc_clock_ctrl_tb_top;
  logic               mclk, rst, por_bor, wr_en, rd_en, prog_mode, clk_run;
  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] wdata, rdata;
  logic               clock_input_pin, clock_output_pin, clock_output_pin_oe;
  logic               clock_input_pin_gpio_free, clock_output_pin_gpio_free;
  logic               fosc_tick, osc_locked_flag, osc_stable_flag;
  int                 n_fail = 0;
  int                 check_count = 0;
  int                 cyc = 0;

  // -----------------------------
  // design and partner
  // -----------------------------
  osc_clock_ctrl osc_clock_ctrl_i (
    .mclk(mclk), .rst(rst), .por_bor(por_bor), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .prog_mode(prog_mode), .rdata(rdata),
    .clock_input_pin(clock_input_pin), .clock_output_pin(clock_output_pin),
    .clock_output_pin_oe(clock_output_pin_oe), .clock_input_pin_gpio_free(clock_input_pin_gpio_free),
    .clock_output_pin_gpio_free(clock_output_pin_gpio_free), .fosc_tick(fosc_tick),
    .osc_locked_flag(osc_locked_flag), .osc_stable_flag(osc_stable_flag)
  );
  ext_clk_src #(.HALF_NS(103)) ext_clk_src_i (.run(clk_run), .clk_pin(clock_input_pin));

  // clock, 20 ns period
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // hang guard, well above the expected run of about 50k cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      end_sim();
    end
  end

  // -----------------------------
  // helpers
  // -----------------------------
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [13:0] near(input longint got, input longint exp);
    return {13'h0, (got >= exp - exp / 32 - 2) && (got <= exp + exp / 32 + 2)};
  endfunction

  task automatic wr(input logic [13:0] a, input logic [13:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [13:0] a, output logic [13:0] d);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask

  task automatic set_cfg(input logic [1:0] m, input logic pll);
    @(posedge mclk);
    prog_mode <= 1'b1;
    wr(`ADDR_CFG1, 14'h2ffc | {1'b0, pll, 10'h0, m});
    @(posedge mclk);
    prog_mode <= 1'b0;
  endtask

  // settle long enough for lock and stable to come up
  task automatic do_rst(input logic por);
    @(posedge mclk);
    rst <= 1'b1;
    por_bor <= por;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    por_bor <= 1'b0;
    repeat (450) @(posedge mclk);
  endtask

  task automatic count(input int win, output int t, output int r);
    logic last;
    t = 0;
    r = 0;
    last = clock_output_pin;
    repeat (win) begin
      @(negedge mclk);
      t += int'(fosc_tick);
      r += int'(clock_output_pin & ~last);
      last = clock_output_pin;
    end
  endtask

  // -----------------------------
  // scenarios
  // -----------------------------
  task automatic t_regs();
    logic [13:0] d;
    rd(`ADDR_CTRL, d);
    check(d, 14'h0020);
    rd(`ADDR_TRIM, d);
    check(d, 14'h0000);
    wr(`ADDR_CFG1, 14'h0000);
    rd(`ADDR_CFG1, d);
    check(d, 14'h0000);
    @(posedge mclk);
    prog_mode <= 1'b1;
    rd(`ADDR_CFG2, d);
    check(d, 14'h3fff);
    @(posedge mclk);
    prog_mode <= 1'b0;
    wr(14'h0012, 14'h3fff);
    rd(14'h0012, d);
    check(d, 14'h0000);
    repeat (450) @(posedge mclk);
    wr(`ADDR_CTRL, 14'h3fff);
    rd(`ADDR_CTRL, d);
    check(d, 14'h003c);
    check({12'h0, osc_locked_flag, osc_stable_flag}, 14'h0003);
  endtask

  // expected pin roles per source code 0..3
  task automatic t_modes();
    logic [2:0] exp [4] = '{3'b011, 3'b110, 3'b001, 3'b100};
    for (int m = 0; m < 4; m++) begin
      set_cfg(2'(m), 1'b1);
      repeat (4) @(posedge mclk);
      check({11'h0, clock_output_pin_oe, clock_input_pin_gpio_free, clock_output_pin_gpio_free}, {11'h0, exp[m]});
    end
  endtask

  // counting starts right after the select write: no settling allowed
  task automatic t_freq(input logic pll);
    int t, r;
    longint e;
    set_cfg(2'h1, pll);
    do_rst(1'b0);
    for (int f = 3; f >= 0; f--) begin
      wr(`ADDR_CTRL, {8'h00, 2'(f), 4'h0});
      count(4000, t, r);
      e = (pll ? 64'd16000000 : 64'd500000) * 4000 / (64'd50000000 << (3 - f));
      check(near(t, e), 14'h0001);
      check(near(r, e / 4), 14'h0001);
    end
  endtask

  task automatic t_trim();
    int t, r;
    logic [13:0] d;
    set_cfg(2'h1, 1'b1);
    do_rst(1'b0);
    wr(`ADDR_CTRL, 14'h0030);
    wr(`ADDR_TRIM, 14'h3fdf);
    rd(`ADDR_TRIM, d);
    check(d, 14'h001f);
    check({13'h0, osc_stable_flag}, 14'h0000);
    repeat (1700) @(posedge mclk);
    count(1000, t, r);
    check(near(t, 320 * 287 / 256), 14'h0001);
    wr(`ADDR_TRIM, 14'h0020);
    repeat (3300) @(posedge mclk);
    count(1000, t, r);
    check(near(t, 320 * 224 / 256), 14'h0001);
    do_rst(1'b0);
    rd(`ADDR_TRIM, d);
    check(d, 14'h0020);
    rd(`ADDR_CTRL, d);
    check(d, 14'h002c);
    do_rst(1'b1);
    rd(`ADDR_TRIM, d);
    check(d, 14'h0000);
  endtask

  // partner clock of 206 ns, unrelated to mclk
  task automatic t_ext();
    int t, r;
    set_cfg(2'h3, 1'b1);
    clk_run <= 1'b1;
    repeat (20) @(posedge mclk);
    count(4000, t, r);
    clk_run <= 1'b0;
    check(near(t, 80000 / 206), 14'h0001);
    check(near(r, 80000 / 824), 14'h0001);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence: power-on reset first, config is undefined before it
  initial begin
    rst = 1'b1;
    por_bor = 1'b1;
    addr = '0;
    wdata = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    prog_mode = 1'b0;
    clk_run = 1'b0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    por_bor <= 1'b0;
    t_regs();
    t_modes();
    t_freq(1'b1);
    t_trim();
    t_freq(1'b0);
    t_ext();
    end_sim();
  end
endmodule // osc_clock_ctrl_tb_top
